// File: dv/dcc_assertions.sv
// Port-level checker for dcc_top: register answers and transfer sequencing.
// Assumes it is bound to dcc_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module dcc_assertions (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic [31:0] prdata_out,
    input  wire logic        pready_out,
    input  wire logic        pslverr_out,
    input  wire logic        ram_en_out,
    input  wire logic        ram_we_out,
    input  wire logic        per_en_out,
    input  wire logic        per_we_out,
    input  wire logic        irq_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    wire rd_ram = ram_en_out && !ram_we_out;
    wire rd_per = per_en_out && !per_we_out;
    wire busy   = ram_en_out || per_en_out;
    AST_READ_UPPER_ZERO: assert property (pready_out |-> prdata_out[31:16] == 16'h0000)
        else $error("upper read data not zero");
    AST_RESET_QUIET: assert property ($fell(rst_in) |-> !ram_en_out && !per_en_out && !irq_out)
        else $error("outputs active right after reset");
    AST_RAM_TO_PER: assert property (rd_ram |=> ##1 (per_en_out && per_we_out))
        else $error("ram read not followed by peripheral write");
    AST_PER_TO_RAM: assert property (rd_per |=> ##1 (ram_en_out && ram_we_out))
        else $error("peripheral read not followed by ram write");
    AST_RAM_WRITE_CAUSE: assert property (ram_en_out && ram_we_out |-> $past(rd_per, 2))
        else $error("ram write without peripheral read");
    AST_ONE_SIDE: assert property (ram_en_out |-> !per_en_out)
        else $error("both sides enabled at once");
    AST_XFER_SPACING: assert property ((rd_ram || rd_per) |=> !busy ##1 busy ##1 !busy)
        else $error("transfer spacing broken");
    AST_ERR_WITH_READY: assert property (pslverr_out |-> pready_out)
        else $error("error without ready");
    cover property (rd_ram);
    cover property (rd_per);
    cover property ($rose(irq_out));
    cover property (pslverr_out);
endmodule // dcc_assertions
`default_nettype wire

// File: dv/dcc_partner.sv
// Behavioural DMA RAM and peripheral register space facing dcc_top.
// Assumes single-cycle ports: read data is valid the cycle after the enable.
`timescale 1ns/1ps
`default_nettype none
module dcc_partner (
    input  wire logic        clk_in,
    input  wire logic        ram_en_in,
    input  wire logic        ram_we_in,
    input  wire logic [15:0] ram_addr_in,
    input  wire logic [15:0] ram_wdata_in,
    output logic      [15:0] ram_rdata_out,
    input  wire logic        per_en_in,
    input  wire logic        per_we_in,
    input  wire logic [15:0] per_addr_in,
    input  wire logic [15:0] per_wdata_in,
    output logic      [15:0] per_rdata_out
);
    logic [15:0] ram_mem [256];
    logic [15:0] per_mem [256];
    initial
    begin
        ram_rdata_out = 16'h0000;
        per_rdata_out = 16'h0000;
        for (int i = 0; i < 256; i++)
        begin
            ram_mem[i] = 16'h5a00 ^ 16'(i);
            per_mem[i] = 16'ha500 ^ 16'(i);
        end
    end
    // Idle data lines flip every cycle so stale values are never mistaken for reads
    always @(posedge clk_in)
    begin
        if (ram_en_in && !ram_we_in) ram_rdata_out <= ram_mem[ram_addr_in[7:0]];
        else ram_rdata_out <= ~ram_rdata_out;
        if (ram_en_in && ram_we_in) ram_mem[ram_addr_in[7:0]] <= ram_wdata_in;
        if (per_en_in && !per_we_in) per_rdata_out <= per_mem[per_addr_in[7:0]];
        else per_rdata_out <= ~per_rdata_out;
        if (per_en_in && per_we_in) per_mem[per_addr_in[7:0]] <= per_wdata_in;
    end
endmodule // dcc_partner
`default_nettype wire

// File: dv/tb.sv
// Self-checking bench for dcc_top over APB with a RAM and peripheral model.
// Assumes dcc_partner and dcc_assertions are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import dcc_pkg::*;
    logic               clk_in, rst_in, psel, penable, pwrite;
    logic [11:0]        paddr;
    logic [31:0]        pwdata;
    logic [NUM_REQ-1:0] req_lines;
    logic [NUM_CH-1:0]  pcol, rcol;
    wire  [31:0]        prdata;
    wire                pready, pslverr, ram_en, ram_we, per_en, per_we, irq;
    wire  [15:0]        ram_addr, ram_wdata, ram_rdata, per_addr, per_wdata, per_rdata;
    int                 mismatches, cmp_count, per_wr_cnt;
    logic [15:0]        wr_addrs[$];
    dcc_top u_dcc_top (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .peripheral_request_line_in(req_lines), .peripheral_collision_in(pcol),
        .ram_collision_in(rcol), .ram_en_out(ram_en), .ram_we_out(ram_we), .ram_addr_out(ram_addr),
        .ram_wdata_out(ram_wdata), .ram_rdata_in(ram_rdata), .per_en_out(per_en), .per_we_out(per_we),
        .per_addr_out(per_addr), .per_wdata_out(per_wdata), .per_rdata_in(per_rdata), .irq_out(irq));
    dcc_partner u_dcc_partner (.clk_in(clk_in), .ram_en_in(ram_en), .ram_we_in(ram_we), .ram_addr_in(ram_addr),
        .ram_wdata_in(ram_wdata), .ram_rdata_out(ram_rdata), .per_en_in(per_en), .per_we_in(per_we),
        .per_addr_in(per_addr), .per_wdata_in(per_wdata), .per_rdata_out(per_rdata));
    initial
    begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end
    always @(posedge clk_in)
    begin
        if (ram_en === 1'b1 && ram_we === 1'b1) wr_addrs.push_back(ram_addr);
        if (per_en === 1'b1 && per_we === 1'b1) per_wr_cnt++;
    end
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        @(posedge clk_in);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk_in);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        r = prdata;
        e = pslverr;
        if (n >= 20) chk("apb answer", 1, pready);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk(nm, exp, r);
    endtask
    function automatic logic [11:0] ra(input int ch, input logic [2:0] idx);
        return {4'h0, 3'(ch), idx, 2'b00};
    endfunction
    task automatic idle(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    // Control goes last so address and count are never changed on a live channel
    task automatic prog(input int ch, input logic [15:0] c, q, a, b, p, n);
        wr(ra(ch, IDX_REQ), {16'h0, q});
        wr(ra(ch, IDX_PRI), {16'h0, a});
        wr(ra(ch, IDX_SEC), {16'h0, b});
        wr(ra(ch, IDX_PAD), {16'h0, p});
        wr(ra(ch, IDX_CNT), {16'h0, n});
        wr(ra(ch, IDX_CTRL), {16'h0, c});
    endtask
    task automatic t_reset();
        for (int c = 0; c < 8; c += 7)
            for (int i = 1; i < 6; i++) rd("reset value", ra(c, 3'(i)), 32'h0);
        rd("collision reset", ADDR_COLL, 32'h0);
        $display("test reset done");
    endtask
    task automatic t_force();
        logic [31:0] r;
        logic        e;
        int          n0;
        wr(ra(3, IDX_REQ), 32'hffffffff);
        rd("request mask", ra(3, IDX_REQ), 32'h807f);
        wr(ra(3, IDX_REQ), 32'h0);
        rd("trigger kept", ra(3, IDX_REQ), 32'h8000);
        wr(ra(3, IDX_CNT), 32'hffffffff);
        rd("count mask", ra(3, IDX_CNT), 32'h3ff);
        for (int i = 2; i < 5; i++)
        begin
            wr(ra(3, 3'(i)), 32'hffffffff);
            rd("address reg", ra(3, 3'(i)), 32'hffff);
        end
        apb(1'b0, 12'h200, 32'h0, r, e);
        chk("unmapped data", 32'h0, r);
        chk("unmapped error", 32'h1, e);
        n0 = per_wr_cnt;
        prog(3, 16'ha001, 16'h0000, 16'h0010, 16'h0018, 16'h0040, 16'h0005);
        idle(40);
        chk("forced transfers", n0 + 1, per_wr_cnt);
        chk("forced data", 16'h5a10, u_dcc_partner.per_mem[8'h40]);
        rd("trigger cleared", ra(3, IDX_REQ), 32'h0);
        wr(ra(3, IDX_CTRL), 32'h0);
        $display("test force done");
    endtask
    task automatic t_request();
        wr_addrs.delete();
        wr(ADDR_IRQ_MK, 32'h0);
        prog(1, 16'h0001, 16'h004d, 16'h0020, 16'h0000, 16'h0044, 16'h0003);
        req_lines[77] <= 1'b1;
        idle(30);
        chk("off channel", 0, wr_addrs.size());
        req_lines[77] <= 1'b0;
        req_lines[76] <= 1'b1;
        wr(ra(1, IDX_CTRL), 32'h8001);
        idle(30);
        chk("other line", 0, wr_addrs.size());
        req_lines[77] <= 1'b1;
        idle(80);
        chk("block length", 4, wr_addrs.size());
        for (int i = 0; i < 4; i++) chk("ram address", 16'h20 + i, wr_addrs[i]);
        chk("ram data", 16'ha544, u_dcc_partner.ram_mem[8'h23]);
        chk("irq masked", 0, irq);
        wr(ADDR_IRQ_MK, 32'h2);
        idle(3);
        chk("irq raised", 1, irq);
        rd("irq status", ADDR_IRQ_ST, 32'h2);
        idle(3);
        chk("irq cleared", 0, irq);
        req_lines <= '0;
        wr(ra(1, IDX_CTRL), 32'h0);
        $display("test request done");
    endtask
    task automatic t_pingpong();
        wr_addrs.delete();
        prog(2, 16'h8003, 16'h0009, 16'h0030, 16'h0038, 16'h0050, 16'h0001);
        req_lines[9] <= 1'b1;
        idle(80);
        chk("ping-pong count", 4, wr_addrs.size());
        for (int i = 0; i < 4; i++) chk("ping-pong address", (i < 2 ? 16'h30 : 16'h36) + i, wr_addrs[i]);
        req_lines <= '0;
        wr(ra(2, IDX_CTRL), 32'h0);
        $display("test ping-pong done");
    endtask
    task automatic t_collision();
        @(posedge clk_in);
        pcol[5] <= 1'b1;
        rcol[2] <= 1'b1;
        @(posedge clk_in);
        pcol <= '0;
        rcol <= '0;
        rd("collision flags", ADDR_COLL, 32'h2004);
        rd("collision sticky", ADDR_COLL, 32'h2004);
        wr(ADDR_COLL, 32'h2000);
        rd("collision clear one", ADDR_COLL, 32'h2000);
        wr(ADDR_COLL, 32'h0);
        rd("collision clear all", ADDR_COLL, 32'h0);
        $display("test collision done");
    endtask
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, req_lines, pcol, rcol} = '0;
        rst_in = 1'b1;
        repeat (16) @(posedge clk_in);
        rst_in <= 1'b0;
        t_reset();
        t_force();
        t_request();
        t_pingpong();
        t_collision();
        end_sim();
    end
    initial
    begin
        #400000;
        mismatches++;
        end_sim();
    end
endmodule // tb
bind dcc_top dcc_assertions u_dcc_assertions (.clk_in, .rst_in, .prdata_out, .pready_out, .pslverr_out,
    .ram_en_out, .ram_we_out, .per_en_out, .per_we_out, .irq_out);
`default_nettype wire

// File: rtl/dcc_channel.sv
// One channel's transfer engine: request pick, addressing, block count.
// Assumes the shared mover grants one access cycle pair at a time.
`timescale 1ns/1ps
`default_nettype none
module dcc_channel
    import dcc_pkg::*;
(
    input  wire logic                  clk_in,
    input  wire logic                  rst_in,
    input  wire logic [15:0]           ctrl_in,
    input  wire logic [6:0]            req_sel_in,
    input  wire logic                  force_in,
    input  wire logic [15:0]           pri_in,
    input  wire logic [15:0]           sec_in,
    input  wire logic [CNT_W-1:0]      cnt_in,
    input  wire logic [NUM_REQ-1:0]    req_lines_in,
    input  wire logic                  grant_in,
    input  wire logic                  step_done_in,
    output logic                       want_out,
    output logic [15:0]                ram_addr_out,
    output logic                       force_done_out,
    output logic                       block_irq_out,
    output logic                       ping_sel_out
);
    wire logic       on_w     = ctrl_in[CTRL_ON];
    wire logic [1:0] mode_w   = ctrl_in[1:0];
    wire logic       pp_w     = mode_w[1];
    wire logic       one_w    = mode_w[0];
    wire logic       req_w    = req_lines_in[req_sel_in];
    logic [CNT_W-1:0] done_q;
    logic             pend_q;
    logic             stop_q;
    logic             ping_q;
    logic             fdone_q;
    logic             birq_q;
    wire logic [CNT_W-1:0] half_w = (cnt_in >> 1);
    wire logic last_w  = (done_q == cnt_in);
    wire logic hit_w   = ctrl_in[CTRL_HALF] ? (done_q == half_w) : last_w;
    wire logic [15:0] base_w = ping_q ? sec_in : pri_in;
    assign want_out       = pend_q;
    assign ram_addr_out   = base_w + {6'h00, done_q};
    assign force_done_out = fdone_q;
    assign block_irq_out  = birq_q;
    assign ping_sel_out   = ping_q;
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            done_q  <= '0;
            pend_q  <= 1'b0;
            stop_q  <= 1'b0;
            ping_q  <= 1'b0;
            fdone_q <= 1'b0;
            birq_q  <= 1'b0;
        end
        else
        begin
            fdone_q <= 1'b0;
            birq_q  <= 1'b0;
            if (!on_w)
            begin
                pend_q <= 1'b0;
                stop_q <= 1'b0;
                done_q <= '0;
                ping_q <= 1'b0;
            end
            else if (step_done_in && grant_in)
            begin
                pend_q  <= 1'b0;
                fdone_q <= force_in;
                birq_q  <= hit_w;
                if (last_w)
                begin
                    done_q <= '0;
                    // One-shot alternating stops after the secondary buffer
                    if (one_w && (!pp_w || ping_q))
                        stop_q <= 1'b1;
                    if (pp_w)
                        ping_q <= ~ping_q;
                end
                else
                    done_q <= done_q + 1'b1;
            end
            // Trigger is cleared one cycle after its transfer; skip that cycle
            else if (!stop_q && ((force_in && !fdone_q) || req_w))
                pend_q <= 1'b1;
        end
    end
endmodule // dcc_channel
`default_nettype wire

// File: rtl/dcc_pkg.sv
// Constants for the eight-channel DMA request, address and count block.
// Assumes a 32-bit APB register bus and one 50 MHz clock.
// Overview of operation
// - Manual trigger bit forces exactly one transfer; otherwise wait for selected request.
// - Writing zero never clears the trigger bit; hardware clears it after the transfer.
// - Seven-bit select picks one of 128 peripheral request lines as the channel request.
// - Each channel holds a 16-bit primary RAM start address.
// - Each channel holds an independent 16-bit secondary RAM start address.
// - Each channel holds a 16-bit peripheral address used on every transfer.
// - A block is the count field plus one transfers.
// - Peripheral collision flags sit in bits 15 to 8, channel 7 highest.
// - RAM collision flags sit in bits 7 to 0, channel 7 highest.
// - Unimplemented bits read zero; all fields reset to zero.
// - A channel moves data only while its enable is one.
// - Direction one reads RAM and writes peripheral; zero the reverse.
// - Mode selects continuous, one-shot, and their alternating-buffer forms.
// - Half select raises block interrupt at half the block, else at the end.
package dcc_pkg;
    localparam int NUM_CH   = 8;
    localparam int NUM_REQ  = 128;
    localparam int CH_WORDS = 8;
    // Per-channel word index within a channel's 32-byte window
    localparam logic [2:0] IDX_CTRL = 3'h0;
    localparam logic [2:0] IDX_REQ  = 3'h1;
    localparam logic [2:0] IDX_PRI  = 3'h2;
    localparam logic [2:0] IDX_SEC  = 3'h3;
    localparam logic [2:0] IDX_PAD  = 3'h4;
    localparam logic [2:0] IDX_CNT  = 3'h5;
    // Shared registers, above the eight channel windows
    localparam logic [11:0] ADDR_COLL   = 12'h100;
    localparam logic [11:0] ADDR_IRQ_ST = 12'h104;
    localparam logic [11:0] ADDR_IRQ_MK = 12'h108;
    localparam logic [11:0] ADDR_CH_TOP = 12'h100;
    localparam int CTRL_ON   = 15;
    localparam int CTRL_DIR  = 13;
    localparam int CTRL_HALF = 12;
    localparam int REQ_FORCE = 15;
    localparam int CNT_W     = 10;
    localparam logic [15:0] CTRL_MASK = 16'hb003;
    localparam logic [15:0] REQ_MASK  = 16'h007f;
    localparam logic [15:0] CNT_MASK  = 16'h03ff;
    localparam logic [15:0] RST_16    = 16'h0000;
    localparam logic [1:0]  MODE_CONT    = 2'h0;
    localparam logic [1:0]  MODE_ONESHOT = 2'h1;
    localparam logic [1:0]  MODE_CONT_PP = 2'h2;
    localparam logic [1:0]  MODE_ONE_PP  = 2'h3;
    typedef enum logic [1:0] {
        DCC_IDLE = 2'b00,
        DCC_READ = 2'b01,
        DCC_WRITE = 2'b11,
        DCC_DONE = 2'b10
    } dcc_state_t;
endpackage

// File: rtl/dcc_top.sv
// Register file, arbiter and data mover for the eight DMA channels.
// Assumes an APB master, a single-cycle DMA RAM and a single-cycle peripheral port.
`timescale 1ns/1ps
`default_nettype none
module dcc_top
    import dcc_pkg::*;
(
    input  wire logic                        clk_in,
    input  wire logic                        rst_in,
    input  wire logic                        psel_in,
    input  wire logic                        penable_in,
    input  wire logic                        pwrite_in,
    input  wire logic [11:0]                 paddr_in,
    input  wire logic [31:0]                 pwdata_in,
    output logic [31:0]                      prdata_out,
    output logic                             pready_out,
    output logic                             pslverr_out,
    input  wire logic [dcc_pkg::NUM_REQ-1:0] peripheral_request_line_in,
    input  wire logic [dcc_pkg::NUM_CH-1:0]  peripheral_collision_in,
    input  wire logic [dcc_pkg::NUM_CH-1:0]  ram_collision_in,
    output logic                             ram_en_out,
    output logic                             ram_we_out,
    output logic [15:0]                      ram_addr_out,
    output logic [15:0]                      ram_wdata_out,
    input  wire logic [15:0]                 ram_rdata_in,
    output logic                             per_en_out,
    output logic                             per_we_out,
    output logic [15:0]                      per_addr_out,
    output logic [15:0]                      per_wdata_out,
    input  wire logic [15:0]                 per_rdata_in,
    output logic                             irq_out
);
    import dcc_pkg::*;
    logic [15:0] ctrl_q [NUM_CH];
    logic [6:0]  sel_q  [NUM_CH];
    logic [15:0] pri_q  [NUM_CH];
    logic [15:0] sec_q  [NUM_CH];
    logic [15:0] pad_q  [NUM_CH];
    logic [CNT_W-1:0] cnt_q [NUM_CH];
    logic [NUM_CH-1:0] force_q;
    logic [15:0] coll_q;
    logic [NUM_CH-1:0] ist_q;
    logic [NUM_CH-1:0] imask_q;
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;
    logic        irq_q;
    dcc_state_t  state_q;
    logic [2:0]  cur_q;
    // Mover strobes and buses, each a flip-flop so the ports never glitch
    logic        ram_en_q;
    logic        ram_we_q;
    logic        per_en_q;
    logic        per_we_q;
    logic [15:0] ram_addr_q;
    logic [15:0] ram_wdata_q;
    logic [15:0] per_addr_q;
    logic [15:0] per_wdata_q;
    wire logic [NUM_CH-1:0] want_w;
    wire logic [NUM_CH-1:0] fdone_w;
    wire logic [NUM_CH-1:0] birq_w;
    wire logic [15:0] caddr_w [NUM_CH];
    wire logic [NUM_CH-1:0] step_w;

    // Access phase of a transfer; the slave answers one cycle later, from registered pready
    wire logic acc_w   = psel_in && penable_in && !pready_q;
    wire logic wr_w    = acc_w && pwrite_in;
    wire logic rd_w    = acc_w && !pwrite_in;
    wire logic in_ch_w = (paddr_in < ADDR_CH_TOP) && (paddr_in[1:0] == 2'h0);
    wire logic [2:0] ch_w  = paddr_in[7:5];
    wire logic [2:0] idx_w = paddr_in[4:2];
    wire logic [15:0] wd_w = pwdata_in[15:0];

    function automatic logic hit(input logic in_ch, input logic [2:0] ix, input logic [2:0] want_ix);
        hit = in_ch && (ix == want_ix);
    endfunction

    wire logic ok_w;
    assign ok_w = (in_ch_w && idx_w <= IDX_CNT)
                  || paddr_in == ADDR_COLL
                  || paddr_in == ADDR_IRQ_ST
                  || paddr_in == ADDR_IRQ_MK;

    // Unused offsets read as zero and answer with an error
    logic [15:0] rd_w16;
    always_comb
    begin
        rd_w16 = 16'h0000;
        if (hit(in_ch_w, idx_w, IDX_CTRL))
            rd_w16 = ctrl_q[ch_w];
        else if (hit(in_ch_w, idx_w, IDX_REQ))
            rd_w16 = {force_q[ch_w], 8'h00, sel_q[ch_w]};
        else if (hit(in_ch_w, idx_w, IDX_PRI))
            rd_w16 = pri_q[ch_w];
        else if (hit(in_ch_w, idx_w, IDX_SEC))
            rd_w16 = sec_q[ch_w];
        else if (hit(in_ch_w, idx_w, IDX_PAD))
            rd_w16 = pad_q[ch_w];
        else if (hit(in_ch_w, idx_w, IDX_CNT))
            rd_w16 = {6'h00, cnt_q[ch_w]};
        else if (paddr_in == ADDR_COLL)
            rd_w16 = coll_q;
        else if (paddr_in == ADDR_IRQ_ST)
            rd_w16 = {8'h00, ist_q};
        else if (paddr_in == ADDR_IRQ_MK)
            rd_w16 = {8'h00, imask_q};
    end

    // Fixed priority: lowest pending channel wins
    logic [2:0] pick_w;
    logic       any_w;
    always_comb
    begin
        pick_w = 3'h0;
        any_w  = 1'b0;
        for (int i = NUM_CH - 1; i >= 0; i--)
        begin
            if (want_w[i])
            begin
                pick_w = 3'(i);
                any_w  = 1'b1;
            end
        end
    end

    wire logic dir_w = ctrl_q[cur_q][CTRL_DIR];

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++)
        begin : g_ch
            // Software write aimed at this channel's window
            wire logic wr_sel_w = wr_w && in_ch_w && (ch_w == 3'(g));
            assign step_w[g] = (state_q == DCC_DONE) && (cur_q == 3'(g));
            dcc_channel u_ch (
                .clk_in         (clk_in),
                .rst_in         (rst_in),
                .ctrl_in        (ctrl_q[g]),
                .req_sel_in     (sel_q[g]),
                .force_in       (force_q[g]),
                .pri_in         (pri_q[g]),
                .sec_in         (sec_q[g]),
                .cnt_in         (cnt_q[g]),
                .req_lines_in   (peripheral_request_line_in),
                .grant_in       (step_w[g]),
                .step_done_in   (step_w[g]),
                .want_out       (want_w[g]),
                .ram_addr_out   (caddr_w[g]),
                .force_done_out (fdone_w[g]),
                .block_irq_out  (birq_w[g]),
                .ping_sel_out   ()
            );

            always_ff @(posedge clk_in or posedge rst_in)
            begin
                if (rst_in)
                begin
                    ctrl_q[g]  <= RST_16;
                    sel_q[g]   <= 7'h00;
                    pri_q[g]   <= RST_16;
                    sec_q[g]   <= RST_16;
                    pad_q[g]   <= RST_16;
                    cnt_q[g]   <= '0;
                    force_q[g] <= 1'b0;
                end
                else
                begin
                    if (wr_sel_w)
                    begin
                        if (idx_w == IDX_CTRL)
                            ctrl_q[g] <= wd_w & CTRL_MASK;
                        if (idx_w == IDX_REQ)
                            sel_q[g] <= wd_w[6:0];
                        if (idx_w == IDX_PRI)
                            pri_q[g] <= wd_w;
                        if (idx_w == IDX_SEC)
                            sec_q[g] <= wd_w;
                        if (idx_w == IDX_PAD)
                            pad_q[g] <= wd_w;
                        if (idx_w == IDX_CNT)
                            cnt_q[g] <= wd_w[CNT_W-1:0];
                    end
                    // Software may set but never clear; a fresh set beats completion
                    if (wr_sel_w && idx_w == IDX_REQ && wd_w[REQ_FORCE])
                        force_q[g] <= 1'b1;
                    else if (fdone_w[g])
                        force_q[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // Write zero clears a flag; a new collision in the same cycle keeps it set
    wire logic [15:0] coll_set_w = {peripheral_collision_in, ram_collision_in};
    wire logic [15:0] coll_keep_w = (wr_w && paddr_in == ADDR_COLL) ? (coll_q & wd_w) : coll_q;
    wire logic [NUM_CH-1:0] ist_keep_w = (rd_w && paddr_in == ADDR_IRQ_ST) ? '0 : ist_q;
    // A block event landing in the read-clear cycle survives the clear
    wire logic [NUM_CH-1:0] ist_next_w = ist_keep_w | birq_w;

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            coll_q    <= RST_16;
            ist_q     <= '0;
            imask_q   <= '0;
            prdata_q  <= 32'h0000_0000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            irq_q     <= 1'b0;
        end
        else
        begin
            coll_q   <= coll_keep_w | coll_set_w;
            ist_q    <= ist_next_w;
            irq_q    <= |(ist_next_w & imask_q);
            pready_q <= acc_w;
            pslverr_q <= acc_w && !ok_w;
            if (wr_w && paddr_in == ADDR_IRQ_MK)
                imask_q <= wd_w[NUM_CH-1:0];
            if (rd_w)
                prdata_q <= {16'h0000, rd_w16};
        end
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            state_q     <= DCC_IDLE;
            cur_q       <= 3'h0;
            ram_en_q    <= 1'b0;
            ram_we_q    <= 1'b0;
            per_en_q    <= 1'b0;
            per_we_q    <= 1'b0;
            ram_addr_q  <= 16'h0000;
            ram_wdata_q <= 16'h0000;
            per_addr_q  <= 16'h0000;
            per_wdata_q <= 16'h0000;
        end
        else
        begin
            ram_en_q <= 1'b0;
            ram_we_q <= 1'b0;
            per_en_q <= 1'b0;
            per_we_q <= 1'b0;
            case (state_q)
                DCC_IDLE:
                begin
                    if (any_w)
                    begin
                        cur_q   <= pick_w;
                        state_q <= DCC_READ;
                        ram_addr_q <= caddr_w[pick_w];
                        per_addr_q <= pad_q[pick_w];
                        if (ctrl_q[pick_w][CTRL_DIR])
                            ram_en_q <= 1'b1;
                        else
                            per_en_q <= 1'b1;
                    end
                end
                DCC_READ:
                    state_q <= DCC_WRITE;
                DCC_WRITE:
                begin
                    state_q <= DCC_DONE;
                    if (dir_w)
                    begin
                        per_en_q    <= 1'b1;
                        per_we_q    <= 1'b1;
                        per_wdata_q <= ram_rdata_in;
                    end
                    else
                    begin
                        ram_en_q    <= 1'b1;
                        ram_we_q    <= 1'b1;
                        ram_wdata_q <= per_rdata_in;
                    end
                end
                DCC_DONE:
                    state_q <= DCC_IDLE;
                default:
                    state_q <= DCC_IDLE;
            endcase
        end
    end

    assign prdata_out    = prdata_q;
    assign pready_out    = pready_q;
    assign pslverr_out   = pslverr_q;
    assign irq_out       = irq_q;
    assign ram_en_out    = ram_en_q;
    assign ram_we_out    = ram_we_q;
    assign ram_addr_out  = ram_addr_q;
    assign ram_wdata_out = ram_wdata_q;
    assign per_en_out    = per_en_q;
    assign per_we_out    = per_we_q;
    assign per_addr_out  = per_addr_q;
    assign per_wdata_out = per_wdata_q;
endmodule // dcc_top
`default_nettype wire
